// ### logic/cdc_defines.svh
// Functional notes
// - with auto crossover off, the crossover state select bit picks the tested pair.
// - test sends pulses, times the reflection, reports electrical length in channel length.
// - any active link is dropped while a reflectometry test runs.
// - matched length estimation covers 100 Mb links up to 120 m, all cable types.
// - two modes: reflectometry on one pair, and matched length on a 100 Mb link.
`ifndef CDC_DEFINES_SVH
`define CDC_DEFINES_SVH

// register byte offsets
`define CDC_OFS_REFL      4'h0
`define CDC_OFS_MATCH     4'h4
`define CDC_OFS_IRQ_STAT  4'h8
`define CDC_OFS_IRQ_MASK  4'hc

// reflectometry control/status fields
`define CDC_REFL_EN_BIT    15
`define CDC_REFL_DONE_BIT  14
`define CDC_REFL_XSEL_BIT  13
`define CDC_REFL_NOECHO_BIT 12
`define CDC_REFL_LEN_LSB   0

// matched length fields
`define CDC_MATCH_CODE_LSB  0
`define CDC_MATCH_VALID_BIT 4

// interrupt status/mask bits
`define CDC_IRQ_DONE_BIT   0
`define CDC_IRQ_LINK_BIT   1
`define CDC_IRQ_W          2

// reset values
`define CDC_RST_IRQ_MASK   2'h0
`define CDC_RST_XSEL       1'b0
`define CDC_RST_MATCH_CODE 4'h0

// timing
`define CDC_CLK_MHZ        250
`define CDC_QUIET_NS       2000
`define CDC_PULSE_NS       16
`define CDC_TICK_NS        8
`define CDC_QUIET_CYC      ((`CDC_QUIET_NS * `CDC_CLK_MHZ + 999) / 1000)
`define CDC_PULSE_CYC      ((`CDC_PULSE_NS * `CDC_CLK_MHZ + 999) / 1000)
`define CDC_TICK_CYC       ((`CDC_TICK_NS * `CDC_CLK_MHZ + 999) / 1000)

`endif

// ### logic/cdc_pkg.sv
`default_nettype none
package cdc_pkg;

  // reflectometry sequence
  typedef enum logic [1:0] {
    CDC_IDLE   = 2'b00,
    CDC_QUIET  = 2'b01,
    CDC_PULSE  = 2'b10,
    CDC_LISTEN = 2'b11
  } cdc_state_t;

endpackage
`default_nettype wire

// ### logic/cdc_echo_timer.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_echo_timer #(
  parameter int LEN_W    = 8,
  parameter int TICK_CYC = 2
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // control
  input  wire logic             clear_i,
  input  wire logic             run_i,
  // result
  output logic [LEN_W-1:0]      len_o,
  output logic                  sat_o
);

  localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

  logic [TW-1:0]    tick_reg;
  logic [TW-1:0]    tick_next;
  logic [LEN_W-1:0] len_next;
  logic             sat_next;
  wire              tick_end = (tick_reg == TW'(TICK_CYC - 1));
  wire              len_full = (len_o == {LEN_W{1'b1}});

  // prescaler turns clock cycles into electrical length units
  assign tick_next = (clear_i || !run_i || tick_end) ? '0 : tick_reg + 1'b1;
  // length saturates rather than wraps so a far echo never reads as a near one
  assign len_next  = clear_i ? '0 :
                     (run_i && tick_end && !len_full) ? len_o + 1'b1 : len_o;
  assign sat_next  = clear_i ? 1'b0 : (sat_o | (run_i && tick_end && len_full));

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tick_reg <= '0;
      len_o    <= '0;
      sat_o    <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      len_o    <= len_next;
      sat_o    <= sat_next;
    end
  end

endmodule // cdc_echo_timer
`default_nettype wire

// ### logic/cdc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cdc_defines.svh"
module cdc_top #(
  parameter int LEN_W     = 8,
  parameter int QUIET_CYC = `CDC_QUIET_CYC,
  parameter int PULSE_CYC = `CDC_PULSE_CYC,
  parameter int TICK_CYC  = `CDC_TICK_CYC
) (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // interrupt
  output logic             IRQ_O,
  // line side front end
  output logic             LINE_PULSE_O,
  output logic             LINE_PAIR_SEL_O,
  input  wire logic        LINE_ECHO_I,
  output logic             LINK_FORCE_DOWN_O,
  // phy status
  input  wire logic        LINK_UP_I,
  input  wire logic        SPEED_100_I,
  input  wire logic        AUTO_XOVER_EN_I,
  input  wire logic        XOVER_STATE_I,
  input  wire logic        FIBER_MODE_I,
  input  wire logic [3:0]  MATCH_CODE_I
);

  // elaboration checks
  if (LEN_W < 4 || LEN_W > 12) begin : g_bad_len
    $error("cdc_top: LEN_W must lie in 4..12");
  end
  if (QUIET_CYC < 1 || QUIET_CYC > 65535 || PULSE_CYC < 1 || PULSE_CYC > 65535) begin : g_bad_t
    $error("cdc_top: QUIET_CYC and PULSE_CYC must lie in 1..65535");
  end
  if (TICK_CYC < 1) begin : g_bad_tick
    $error("cdc_top: TICK_CYC must be at least 1");
  end

  // byte-lane merge used for every writable register
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // state
  cdc_pkg::cdc_state_t    state_reg;
  cdc_pkg::cdc_state_t    state_next;
  logic [15:0]            wait_reg;
  logic [15:0]            wait_next;
  logic                   en_reg;
  logic                   en_next;
  logic                   done_reg;
  logic                   done_next;
  logic                   noecho_reg;
  logic                   noecho_next;
  logic                   xsel_reg;
  logic                   xsel_next;
  logic [LEN_W-1:0]       len_reg;
  logic [LEN_W-1:0]       len_next;
  logic [3:0]             match_code_reg;
  logic [3:0]             match_code_next;
  logic                   match_valid_reg;
  logic [`CDC_IRQ_W-1:0]  irq_stat_reg;
  logic [`CDC_IRQ_W-1:0]  irq_stat_next;
  logic [`CDC_IRQ_W-1:0]  irq_mask_reg;
  logic [`CDC_IRQ_W-1:0]  irq_mask_next;
  logic                   ack_reg;
  logic [31:0]            rdata_reg;
  logic [31:0]            rdata_next;
  logic                   pulse_reg;
  logic                   pair_reg;
  logic                   drop_reg;
  logic [LEN_W-1:0]       timer_len;
  logic                   timer_sat;

  // bus handshake: one wait cycle, then the request is taken
  wire bus_req  = AVS_READ_I | AVS_WRITE_I;
  wire bus_take = bus_req & ack_reg;
  wire wr_take  = bus_take & AVS_WRITE_I;
  wire rd_take  = bus_take & AVS_READ_I;
  wire rd_load  = AVS_READ_I & ~ack_reg;

  // address decode
  wire sel_refl  = (AVS_ADDRESS_I == `CDC_OFS_REFL);
  wire sel_match = (AVS_ADDRESS_I == `CDC_OFS_MATCH);
  wire sel_stat  = (AVS_ADDRESS_I == `CDC_OFS_IRQ_STAT);
  wire sel_mask  = (AVS_ADDRESS_I == `CDC_OFS_IRQ_MASK);

  // register images
  wire [31:0] refl_img;
  assign refl_img = {16'h0000, en_reg, done_reg, xsel_reg, noecho_reg,
                     12'(len_reg)};
  wire [31:0] match_img = {27'h0000000, match_valid_reg, match_code_reg};
  wire [31:0] stat_img  = {{(32-`CDC_IRQ_W){1'b0}}, irq_stat_reg};
  wire [31:0] mask_img  = {{(32-`CDC_IRQ_W){1'b0}}, irq_mask_reg};

  // read mux; unmapped offsets read zero
  assign rdata_next = !rd_load  ? AVS_READDATA_O :
                      sel_refl  ? refl_img  :
                      sel_match ? match_img :
                      sel_stat  ? stat_img  :
                      sel_mask  ? mask_img  : 32'h00000000;

  // control write decode
  wire [31:0] refl_wr   = be_merge(refl_img, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  wire        refl_wr_t = wr_take & sel_refl;
  wire        busy      = (state_reg != cdc_pkg::CDC_IDLE);
  // a start is refused in fiber mode, where no copper pair exists
  wire        start_req = refl_wr_t & refl_wr[`CDC_REFL_EN_BIT] & ~busy & ~FIBER_MODE_I;
  // clearing the enable bit mid-test aborts without a done flag
  wire        abort_req = refl_wr_t & ~refl_wr[`CDC_REFL_EN_BIT] & busy;

  // sequencer status
  wire wait_end  = (wait_reg == 16'h0000);
  wire echo_hit  = (state_reg == cdc_pkg::CDC_LISTEN) & LINE_ECHO_I;
  wire echo_none = (state_reg == cdc_pkg::CDC_LISTEN) & timer_sat & ~LINE_ECHO_I;
  wire finish    = echo_hit | echo_none;
  wire timer_run = (state_reg == cdc_pkg::CDC_PULSE) | (state_reg == cdc_pkg::CDC_LISTEN);

  // reflectometry sequence: drop link, let line settle, pulse, listen
  always_comb begin
    state_next = state_reg;
    wait_next  = wait_end ? wait_reg : wait_reg - 16'h0001;
    if (abort_req) begin
      state_next = cdc_pkg::CDC_IDLE;
      wait_next  = 16'h0000;
    end else begin
      case (state_reg)
        cdc_pkg::CDC_IDLE: begin
          if (start_req) begin
            state_next = cdc_pkg::CDC_QUIET;
            wait_next  = 16'(QUIET_CYC - 1);
          end
        end
        cdc_pkg::CDC_QUIET: begin
          if (wait_end) begin
            state_next = cdc_pkg::CDC_PULSE;
            wait_next  = 16'(PULSE_CYC - 1);
          end
        end
        cdc_pkg::CDC_PULSE: begin
          if (wait_end) begin
            state_next = cdc_pkg::CDC_LISTEN;
          end
        end
        cdc_pkg::CDC_LISTEN: begin
          if (finish) begin
            state_next = cdc_pkg::CDC_IDLE;
          end
        end
        default: begin
          state_next = cdc_pkg::CDC_IDLE;
        end
      endcase
    end
  end

  // result capture: cleared at start, held until the next start; enable set at start, cleared at finish or abort
  assign en_next     = start_req ? 1'b1 : ((finish | abort_req) ? 1'b0 : en_reg);
  assign done_next   = start_req ? 1'b0 : (finish ? 1'b1 : done_reg);
  assign len_next    = start_req ? '0 : (echo_hit ? timer_len : len_reg);
  // no echo means a matched line; the length field is then meaningless
  assign noecho_next = start_req ? 1'b0 : (echo_none ? 1'b1 : noecho_reg);
  // pair select is frozen while a test runs
  assign xsel_next   = (refl_wr_t & ~busy) ? refl_wr[`CDC_REFL_XSEL_BIT] : xsel_reg;

  // matched length: tracks the estimate only on a 100 Mb link
  wire link100 = LINK_UP_I & SPEED_100_I & ~busy;
  assign match_code_next = link100 ? MATCH_CODE_I : match_code_reg;

  // interrupt events: set beats a clearing read in the same cycle
  wire [`CDC_IRQ_W-1:0] irq_set;
  assign irq_set[`CDC_IRQ_DONE_BIT] = finish;
  assign irq_set[`CDC_IRQ_LINK_BIT] = link100 ^ match_valid_reg;
  wire [`CDC_IRQ_W-1:0] irq_clr = (rd_take & sel_stat) ? {`CDC_IRQ_W{1'b1}} : '0;
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
  wire [31:0] mask_wr = be_merge(mask_img, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  assign irq_mask_next = (wr_take & sel_mask) ? mask_wr[`CDC_IRQ_W-1:0] : irq_mask_reg;

  // bus outputs
  assign AVS_WAITREQUEST_O = bus_req & ~ack_reg;
  assign IRQ_O             = |(irq_stat_reg & irq_mask_reg);

  // line outputs from flops
  assign LINE_PULSE_O      = pulse_reg;
  assign LINE_PAIR_SEL_O   = pair_reg;
  assign LINK_FORCE_DOWN_O = drop_reg;

  // pair: register bit with auto crossover off, live state otherwise
  // next value used so the pair is already right in the first quiet cycle
  wire pair_next = AUTO_XOVER_EN_I ? XOVER_STATE_I : xsel_next;

  // sequencer registers
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      state_reg <= cdc_pkg::CDC_IDLE;
      wait_reg  <= 16'h0000;
      pulse_reg <= 1'b0;
      pair_reg  <= `CDC_RST_XSEL;
      drop_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      pulse_reg <= (state_next == cdc_pkg::CDC_PULSE);
      pair_reg  <= pair_next;
      drop_reg  <= (state_next != cdc_pkg::CDC_IDLE);
    end
  end

  // result and configuration registers
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      en_reg     <= 1'b0;
      done_reg   <= 1'b0;
      noecho_reg <= 1'b0;
      xsel_reg   <= `CDC_RST_XSEL;
      len_reg    <= '0;
    end else begin
      en_reg     <= en_next;
      done_reg   <= done_next;
      noecho_reg <= noecho_next;
      xsel_reg   <= xsel_next;
      len_reg    <= len_next;
    end
  end

  // matched length and interrupt registers
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      match_code_reg  <= `CDC_RST_MATCH_CODE;
      match_valid_reg <= 1'b0;
      irq_stat_reg    <= '0;
      irq_mask_reg    <= `CDC_RST_IRQ_MASK;
    end else begin
      match_code_reg  <= match_code_next;
      match_valid_reg <= link100;
      irq_stat_reg    <= irq_stat_next;
      irq_mask_reg    <= irq_mask_next;
    end
  end

  // bus registers
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ack_reg        <= 1'b0;
      AVS_READDATA_O <= 32'h00000000;
    end else begin
      ack_reg        <= bus_req & ~ack_reg;
      AVS_READDATA_O <= rdata_next;
    end
  end

  // round-trip timer, measured from the first pulse edge
  cdc_echo_timer #(
    .LEN_W    (LEN_W),
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .clk_i   (CLK_I),
    .nrst_i  (NRST_I),
    .clear_i (start_req),
    .run_i   (timer_run),
    .len_o   (timer_len),
    .sat_o   (timer_sat)
  );

endmodule // cdc_top
`default_nettype wire

// ### tb/cdc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_chk #(
  parameter int QUIET_CYC = 4,
  parameter int PULSE_CYC = 2
) (
  // watched top ports
  input wire logic        CLK_I,
  input wire logic        NRST_I,
  input wire logic [3:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        LINE_PULSE_O,
  input wire logic        LINE_PAIR_SEL_O,
  input wire logic        LINK_FORCE_DOWN_O,
  input wire logic        LINK_UP_I,
  input wire logic        SPEED_100_I
);
  localparam int Q_LO = QUIET_CYC - 1;
  localparam int Q_HI = QUIET_CYC + 2;
  logic [7:0] pcnt_reg;
  // request decode; only word offsets are mapped
  wire logic  req = AVS_READ_I | AVS_WRITE_I;
  wire logic  rd_end = AVS_READ_I & ~AVS_WAITREQUEST_O;
  wire logic  unmapped = AVS_ADDRESS_I[1:0] != 2'h0;
  wire logic  lk = LINK_UP_I & SPEED_100_I;
  // pulse width counter, cleared whenever the pulse is low
  always_ff @(posedge CLK_I) begin
    pcnt_reg <= (NRST_I && LINE_PULSE_O) ? pcnt_reg + 8'h01 : 8'h00;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_req_rise;
    $rose(req);
  endsequence
  sequence s_test_rise;
    $rose(LINK_FORCE_DOWN_O);
  endsequence
  wait_first_a: assert property (s_req_rise |-> AVS_WAITREQUEST_O)
    else $error("request taken without a wait cycle");
  wait_one_a: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("wait lasted more than one cycle");
  pulse_len_a: assert property ($fell(LINE_PULSE_O) |-> pcnt_reg == PULSE_CYC)
    else $error("pulse width wrong");
  pulse_in_test_a: assert property (LINE_PULSE_O |-> LINK_FORCE_DOWN_O)
    else $error("pulse outside a test");
  quiet_gap_a: assert property (s_test_rise |-> !LINE_PULSE_O ##[Q_LO:Q_HI] $rose(LINE_PULSE_O))
    else $error("quiet gap wrong");
  pair_stable_a: assert property (LINK_FORCE_DOWN_O && $past(LINK_FORCE_DOWN_O)
    |-> $stable(LINE_PAIR_SEL_O))
    else $error("pair changed during a test");
  unmapped_zero_a: assert property (rd_end && unmapped |-> AVS_READDATA_O == 32'h0)
    else $error("unmapped read not zero");
  test_invalid_a: assert property (rd_end && AVS_ADDRESS_I == 4'h4 && LINK_FORCE_DOWN_O
    && $past(LINK_FORCE_DOWN_O, 2) |-> !AVS_READDATA_O[4])
    else $error("matched length valid during a test");
  nolink_invalid_a: assert property (rd_end && AVS_ADDRESS_I == 4'h4 && !$past(lk)
    && !$past(lk, 2) |-> !AVS_READDATA_O[4])
    else $error("matched length valid without a 100 Mb link");
endmodule // cdc_chk
bind cdc_top cdc_chk #(.QUIET_CYC(QUIET_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .LINE_PULSE_O(LINE_PULSE_O),
  .LINE_PAIR_SEL_O(LINE_PAIR_SEL_O), .LINK_FORCE_DOWN_O(LINK_FORCE_DOWN_O),
  .LINK_UP_I(LINK_UP_I), .SPEED_100_I(SPEED_100_I));
`default_nettype wire

// ### tb/cdc_cable_mdl.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_cable_mdl (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // line side
  input  wire logic       pulse_i,
  input  wire logic       pair_i,
  input  wire logic       force_i,
  output logic            echo_o,
  output logic            link_up_o,
  // fault distance per pair in cycles, 0 for a terminated pair
  input  wire logic       link_cfg_i,
  input  wire logic [3:0] d0_i,
  input  wire logic [3:0] d1_i
);
  logic [3:0] cnt_reg;
  logic       pulse_reg;
  wire logic [3:0] dly = pair_i ? d1_i : d0_i;
  // partner drops its link while the device holds the line down
  assign link_up_o = link_cfg_i & ~force_i;
  // one-cycle reflection a fixed time after the pulse starts
  assign echo_o = (dly != 4'h0) && (cnt_reg == dly);
  always_ff @(posedge clk_i) begin
    pulse_reg <= nrst_i & pulse_i;
    if (!nrst_i) cnt_reg <= 4'h0;
    else if (pulse_i && !pulse_reg) cnt_reg <= 4'h1;
    else if (cnt_reg != 4'h0 && cnt_reg != 4'hf) cnt_reg <= cnt_reg + 4'h1;
  end
endmodule // cdc_cable_mdl
`default_nettype wire

// ### tb/cdc_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_top_tb_top;
  logic        clk, nrst, rd, wr, xauto, xst, fib, spd, lcfg;
  logic [3:0]  addr, be, code, d0, d1;
  logic [31:0] wd, q, q0, q1;
  wire logic [31:0] rdata;
  wire logic   wreq, irq, pulse, pair, fdown, echo, lnk;
  int          err_count, checked;
  cdc_top #(.LEN_W(4), .QUIET_CYC(4), .PULSE_CYC(2), .TICK_CYC(1)) u_dut (
    .CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wreq), .IRQ_O(irq), .LINE_PULSE_O(pulse), .LINE_PAIR_SEL_O(pair),
    .LINE_ECHO_I(echo), .LINK_FORCE_DOWN_O(fdown), .LINK_UP_I(lnk), .SPEED_100_I(spd),
    .AUTO_XOVER_EN_I(xauto), .XOVER_STATE_I(xst), .FIBER_MODE_I(fib), .MATCH_CODE_I(code));
  cdc_cable_mdl u_cable (.clk_i(clk), .nrst_i(nrst), .pulse_i(pulse), .pair_i(pair),
    .force_i(fdown), .echo_o(echo), .link_up_o(lnk), .link_cfg_i(lcfg), .d0_i(d0), .d1_i(d1));
  always #2 clk = ~clk;
  task test_done;
    $display("checked %0d, err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon transfer; waitrequest and read data are taken at the rising edge itself
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
           output logic [31:0] r);
    int n;
    @(posedge clk);
    addr <= a; wr <= w; rd <= !w; wd <= d; be <= b; n = 0;
    do begin @(posedge clk); n++; end while (wreq !== 1'b0 && n < 64);
    if (n >= 64) begin err_count++; test_done; end
    r = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, 4'hf, r);
    chk(r, e);
  endtask
  // start a test, look at the line while it runs, poll for done
  task tdr(input logic [31:0] cmd, input logic ps, output logic [31:0] r);
    int n;
    bus(1'b1, 4'h0, cmd, 4'hf, r);
    @(negedge clk);
    chk(fdown, 1);
    chk(lnk, 0);
    chk(pair, ps);
    rdc(4'h4, 32'h9);
    n = 0; r = 0;
    while (r[14] !== 1'b1 && n < 200) begin bus(1'b0, 4'h0, 32'h0, 4'hf, r); n++; end
    if (n >= 200) begin err_count++; test_done; end
    @(negedge clk);
    chk(irq, 1);
    chk(fdown, 0);
    rdc(4'h8, 32'h3);
  endtask
  initial begin
    clk = 0; nrst = 0; addr = 0; rd = 0; wr = 0; wd = 0; be = 0; xauto = 0; xst = 0;
    fib = 0; spd = 0; lcfg = 0; code = 0; d0 = 4'h3; d1 = 4'h6; err_count = 0; checked = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // reset values, unmapped place, disabled byte lane
    rdc(4'h0, 32'h0);
    rdc(4'hc, 32'h0);
    rdc(4'h8, 32'h0);
    rdc(4'h4, 32'h0);
    bus(1'b1, 4'h2, 32'hffff_ffff, 4'hf, q);
    rdc(4'h2, 32'h0);
    bus(1'b1, 4'h0, 32'h2000, 4'h1, q);
    rdc(4'h0, 32'h0);
    $display("test reset done");
    // matched length, valid only on a 100 Mb link; interrupt raised, masked, cleared
    @(posedge clk);
    lcfg <= 1'b1; spd <= 1'b1; code <= 4'h9;
    repeat (3) @(posedge clk);
    rdc(4'h4, 32'h19);
    @(negedge clk);
    chk(irq, 0);
    bus(1'b1, 4'hc, 32'h3, 4'hf, q);
    rdc(4'hc, 32'h3);
    @(negedge clk);
    chk(irq, 1);
    rdc(4'h8, 32'h2);
    @(negedge clk);
    chk(irq, 0);
    @(posedge clk);
    spd <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(4'h4, 32'h9);
    spd <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(4'h8, 32'h2);
    bus(1'b1, 4'hc, 32'h1, 4'hf, q);
    $display("test matched done");
    // one test per pair, distances 3 and 6 cycles apart by 3
    tdr(32'h8000, 1'b0, q0);
    chk(q0[15:12], 4'h4);
    chk(q0[3:0], d0);
    rdc(4'h0, 32'h4003);
    bus(1'b1, 4'h0, 32'h2000, 4'hf, q);
    tdr(32'ha000, 1'b1, q1);
    chk(q1[15:12], 4'h6);
    chk(q1[3:0] - q0[3:0], 4'h3);
    $display("test pairs done");
    // terminated pair gives no echo
    d1 <= 4'h0;
    tdr(32'ha000, 1'b1, q1);
    chk(q1, 32'h7000);
    $display("test noecho done");
    // start refused in fiber mode, results held
    fib <= 1'b1;
    bus(1'b1, 4'h0, 32'ha000, 4'hf, q);
    @(negedge clk);
    chk(fdown, 0);
    rdc(4'h0, 32'h7000);
    // fiber mode off, auto crossover on: pair follows the live crossover state
    fib <= 1'b0;
    xauto <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(pair, 0);
    $display("test refusal done");
    test_done;
  end
endmodule // cdc_top_tb_top
`default_nettype wire
